/* rcfg_map.svh */
// offsets, field positions, reset values and voltage figures of the config bank
// assumes one 8-bit register per index, reached only over the two-wire port
`ifndef RCFG_MAP_SVH
`define RCFG_MAP_SVH

// ----------------------------------------------------------------
// addressing
// ----------------------------------------------------------------
`define RCFG_SLAVE_ADDR 7'h46
`define RCFG_IDX_NB 8'h00
`define RCFG_IDX_CORE 8'h01
`define RCFG_IDX_PS 8'h02
`define RCFG_NUM_REGS 8'h03

// ----------------------------------------------------------------
// initial states
// ----------------------------------------------------------------
`define RCFG_NB_INIT 8'h00
`define RCFG_CORE_INIT 8'h00
`define RCFG_PS_INIT 8'h01

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RCFG_OVP_BIT 7
`define RCFG_PG_BIT 6
`define RCFG_OFS_MSB 5
`define RCFG_PS_OFS_DIS_BIT 6
`define RCFG_PS_DROP_LSB 4
`define RCFG_PS_ADD_LSB 2
`define RCFG_PS_PH_LSB 0

// ----------------------------------------------------------------
// levels in mV
// ----------------------------------------------------------------
`define RCFG_OVP_FLOOR_MV 12'd1800
`define RCFG_OVP_NORM_MV 13'sd250
`define RCFG_OVP_HIGH_MV 13'sd500
`define RCFG_PGHI_NORM_MV 13'sd250
`define RCFG_PGHI_HIGH_MV 13'sd300
`define RCFG_PGLO_NORM_MV 13'sd300
`define RCFG_PGLO_HIGH_MV 13'sd350
`define RCFG_PG_HYST_MV 13'sd50
`define RCFG_OFS_STEP_MV 11'sd25

`endif

/* rcfg_pkg.sv */
// types shared by the config bank modules
// assumes rcfg_map.svh for all numeric constants
package rcfg_pkg;

    // ----------------------------------------------------------------
    // serial engine states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_REG,
        ST_WDATA,
        ST_ACK,
        ST_RDATA,
        ST_RACK
    } rcfg_state_e;

    typedef logic [11:0] rcfg_mv_t;

endpackage : rcfg_pkg

/* rcfg_line_sync.sv */
// two-wire line sampler: synchronises clock and data, finds edges, start and stop
// assumes both lines come straight from pins, asynchronous to clk
`timescale 1ns/1ps
module rcfg_line_sync (
    input logic clk,
    input logic rst_n,
    input logic scl,
    input logic sda,
    output logic scl_rise,
    output logic scl_fall,
    output logic start_det,
    output logic stop_det,
    output logic sda_lvl
);
    logic [2:0] scl_q;
    logic [2:0] sda_q;
    logic [2:0] scl_d;
    logic [2:0] sda_d;

    // ----------------------------------------------------------------
    // two flops, then one history stage
    // ----------------------------------------------------------------
    always_comb begin
        scl_d = {scl_q[1:0], scl};
        sda_d = {sda_q[1:0], sda};
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
        end else begin
            scl_q <= scl_d;
            sda_q <= sda_d;
        end
    end

    assign scl_rise = scl_q[1] && !scl_q[2];
    assign scl_fall = !scl_q[1] && scl_q[2];
    assign start_det = scl_q[1] && scl_q[2] && sda_q[2] && !sda_q[1];
    assign stop_det = scl_q[1] && scl_q[2] && !sda_q[2] && sda_q[1];
    assign sda_lvl = sda_q[1];

endmodule : rcfg_line_sync

/* rcfg_regs_top.sv */
// What this block does
// - power-up loads 00, 00, 01
// - supply drop forces all registers initial
// - writes accepted anytime once supply good
// - writing initial values resets without disruption
// - sequential write fills registers 0,1,2, acked
// - single read: set pointer, read, nack
// - sequential read returns 0,1,2 while acked
// - stop applies new contents immediately
// - margin registers: ovp, pgood, offset fields
// - ovp trip: max(1.8V, dac+250/500mV)
// - pgood window 250/300, 300/350 mV
// - pgood thresholds carry 50 mV hysteresis
// - offset: signed 25 mV steps
// - savings register: phases, add/drop cycles, disable
//
// config register bank of a dual regulator behind a two-wire slave port
// assumes SCL/SDA/POR_OK from pins; dac levels and SAVE_MODE from MCLK logic
`timescale 1ns/1ps
`include "rcfg_map.svh"
module rcfg_regs_top
    import rcfg_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = `RCFG_SLAVE_ADDR
) (
    input logic MCLK,
    input logic RESETN,
    input logic SCL,
    input logic SDA,
    output logic SDA_DRV,
    output logic SDA_OE,
    input logic POR_OK,
    input logic [11:0] NB_DAC_MV,
    input logic [11:0] CORE_DAC_MV,
    input logic SAVE_MODE,
    output logic [7:0] NB_MARGIN,
    output logic [7:0] CORE_MARGIN,
    output logic [7:0] PS_CTRL,
    output logic [11:0] NB_TARGET_MV,
    output logic [11:0] CORE_TARGET_MV,
    output logic signed [10:0] NB_OFFSET_MV,
    output logic signed [10:0] CORE_OFFSET_MV,
    output logic [11:0] NB_OVP_MV,
    output logic [11:0] CORE_OVP_MV,
    output logic [11:0] CORE_PG_HI_MV,
    output logic [11:0] CORE_PG_LO_MV,
    output logic [11:0] NB_PG_LO_MV,
    output logic [11:0] CORE_PG_HI_REL_MV,
    output logic [11:0] CORE_PG_LO_REL_MV,
    output logic [11:0] NB_PG_LO_REL_MV,
    output logic [1:0] PS_PHASES,
    output logic [2:0] PS_ADD_CYC,
    output logic [2:0] PS_DROP_CYC,
    output logic CORE_OFS_OFF
);
    localparam logic [7:0] INIT_V [0:2] = '{`RCFG_NB_INIT, `RCFG_CORE_INIT, `RCFG_PS_INIT};

    logic scl_rise, scl_fall, start_det, stop_det, sda_lvl;
    logic por_m_q, por_ok;
    rcfg_state_e st_q, st_d, aft_q, aft_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d, tx_q, tx_d, ptr_q, ptr_d;
    logic oe_q, oe_d, mack_q, mack_d, seen_q;
    logic [7:0] shd_q [0:2];
    logic [7:0] shd_d [0:2];
    logic [7:0] app_q [0:2];
    logic [7:0] app_d [0:2];
    logic quiet;

    rcfg_line_sync u_line (
        .clk(MCLK),
        .rst_n(RESETN),
        .scl(SCL),
        .sda(SDA),
        .scl_rise(scl_rise),
        .scl_fall(scl_fall),
        .start_det(start_det),
        .stop_det(stop_det),
        .sda_lvl(sda_lvl)
    );

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] rd_byte(input logic [7:0] p);
        logic [7:0] v;
        v = 8'h00;
        if (p < `RCFG_NUM_REGS) begin
            v = shd_q[p[1:0]];
        end
        return v;
    endfunction : rd_byte

    function automatic rcfg_mv_t sat12(input rcfg_mv_t base, input logic signed [12:0] dl);
        logic signed [13:0] s;
        s = $signed({2'b00, base}) + $signed({dl[12], dl});
        if (s < 14'sd0) begin
            return 12'h000;
        end else if (s > 14'sd4095) begin
            return 12'hfff;
        end
        return s[11:0];
    endfunction : sat12

    function automatic logic [2:0] cyc_of(input logic [1:0] c);
        case (c)
            2'h0: return 3'h1;
            2'h1: return 3'h2;
            2'h2: return 3'h4;
            default: return 3'h0;
        endcase
    endfunction : cyc_of

    // ----------------------------------------------------------------
    // supply-good sync
    // ----------------------------------------------------------------
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            por_m_q <= 1'b0;
            por_ok <= 1'b0;
            seen_q <= 1'b0;
        end else begin
            por_m_q <= POR_OK;
            por_ok <= por_m_q;
            seen_q <= 1'b1;
        end
    end

    assign quiet = por_ok && !start_det && !stop_det;

    // ----------------------------------------------------------------
    // serial engine and register bank
    // ----------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        aft_d = aft_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        tx_d = tx_q;
        ptr_d = ptr_q;
        oe_d = oe_q;
        mack_d = mack_q;
        shd_d = shd_q;
        app_d = app_q;
        if (start_det) begin
            st_d = ST_ADDR;
            cnt_d = 4'h0;
            oe_d = 1'b0;
        end else if (stop_det) begin
            st_d = ST_IDLE;
            oe_d = 1'b0;
            app_d = shd_q;
        end else begin
            case (st_q)
                ST_ADDR, ST_REG, ST_WDATA: begin
                    if (scl_rise && cnt_q != 4'h8) begin
                        sh_d = {sh_q[6:0], sda_lvl};
                        cnt_d = cnt_q + 4'h1;
                    end
                    if (scl_fall && cnt_q == 4'h8) begin
                        st_d = ST_IDLE;
                        if (st_q == ST_ADDR && sh_q[7:1] == SLAVE_ADDR) begin
                            oe_d = 1'b1;
                            st_d = ST_ACK;
                            aft_d = sh_q[0] ? ST_RDATA : ST_REG;
                        end else if (st_q == ST_REG && sh_q < `RCFG_NUM_REGS) begin
                            oe_d = 1'b1;
                            st_d = ST_ACK;
                            aft_d = ST_WDATA;
                            ptr_d = sh_q;
                        end else if (st_q == ST_WDATA && ptr_q < `RCFG_NUM_REGS) begin
                            oe_d = 1'b1;
                            st_d = ST_ACK;
                            aft_d = ST_WDATA;
                            shd_d[ptr_q[1:0]] = sh_q;
                            ptr_d = ptr_q + 8'h01;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        st_d = aft_q;
                        cnt_d = 4'h0;
                        oe_d = 1'b0;
                        if (aft_q == ST_RDATA) begin
                            tx_d = rd_byte(ptr_q);
                            oe_d = !tx_d[7];
                        end
                    end
                end
                ST_RDATA: begin
                    if (scl_rise) begin
                        cnt_d = cnt_q + 4'h1;
                    end
                    if (scl_fall) begin
                        if (cnt_q == 4'h8) begin
                            oe_d = 1'b0;
                            st_d = ST_RACK;
                        end else begin
                            tx_d = {tx_q[6:0], 1'b0};
                            oe_d = !tx_q[6];
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        mack_d = !sda_lvl;
                    end
                    if (scl_fall) begin
                        ptr_d = ptr_q + 8'h01;
                        st_d = ST_IDLE;
                        if (mack_q) begin
                            st_d = ST_RDATA;
                            cnt_d = 4'h0;
                            tx_d = rd_byte(ptr_q + 8'h01);
                            oe_d = !tx_d[7];
                        end
                    end
                end
                default: begin
                    oe_d = 1'b0;
                end
            endcase
        end
        if (!por_ok) begin
            st_d = ST_IDLE;
            oe_d = 1'b0;
            shd_d = INIT_V;
            app_d = INIT_V;
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            st_q <= ST_IDLE;
            aft_q <= ST_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            tx_q <= 8'h00;
            ptr_q <= 8'h00;
            oe_q <= 1'b0;
            mack_q <= 1'b0;
            shd_q <= INIT_V;
            app_q <= INIT_V;
        end else begin
            st_q <= st_d;
            aft_q <= aft_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            tx_q <= tx_d;
            ptr_q <= ptr_d;
            oe_q <= oe_d;
            mack_q <= mack_d;
            shd_q <= shd_d;
            app_q <= app_d;
        end
    end

    assign NB_MARGIN = app_q[0];
    assign CORE_MARGIN = app_q[1];
    assign PS_CTRL = app_q[2];
    assign SDA_OE = oe_q;

    // ----------------------------------------------------------------
    // operating levels from applied contents
    // ----------------------------------------------------------------
    logic signed [10:0] nbo_d, coo_d;
    rcfg_mv_t nbt_d, cot_d, nbv_d, cov_d, chi_d, clo_d, nlo_d;
    logic ofs_off_d;

    always_comb begin
        nbo_d = $signed({{5{app_q[0][`RCFG_OFS_MSB]}}, app_q[0][5:0]}) * `RCFG_OFS_STEP_MV;
        coo_d = $signed({{5{app_q[1][`RCFG_OFS_MSB]}}, app_q[1][5:0]}) * `RCFG_OFS_STEP_MV;
        ofs_off_d = SAVE_MODE && app_q[2][`RCFG_PS_OFS_DIS_BIT];
        nbt_d = sat12(NB_DAC_MV, {{2{nbo_d[10]}}, nbo_d});
        cot_d = ofs_off_d ? CORE_DAC_MV : sat12(CORE_DAC_MV, {{2{coo_d[10]}}, coo_d});
        nbv_d = sat12(NB_DAC_MV, app_q[0][`RCFG_OVP_BIT] ? `RCFG_OVP_HIGH_MV : `RCFG_OVP_NORM_MV);
        cov_d = sat12(CORE_DAC_MV, app_q[1][`RCFG_OVP_BIT] ? `RCFG_OVP_HIGH_MV : `RCFG_OVP_NORM_MV);
        if (nbv_d < `RCFG_OVP_FLOOR_MV) begin
            nbv_d = `RCFG_OVP_FLOOR_MV;
        end
        if (cov_d < `RCFG_OVP_FLOOR_MV) begin
            cov_d = `RCFG_OVP_FLOOR_MV;
        end
        chi_d = sat12(CORE_DAC_MV, app_q[1][`RCFG_PG_BIT] ? `RCFG_PGHI_HIGH_MV : `RCFG_PGHI_NORM_MV);
        clo_d = sat12(CORE_DAC_MV, app_q[1][`RCFG_PG_BIT] ? -`RCFG_PGLO_HIGH_MV : -`RCFG_PGLO_NORM_MV);
        nlo_d = sat12(NB_DAC_MV, app_q[0][`RCFG_PG_BIT] ? -`RCFG_PGLO_HIGH_MV : -`RCFG_PGLO_NORM_MV);
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            SDA_DRV <= 1'b0;
            NB_OFFSET_MV <= 11'sd0;
            CORE_OFFSET_MV <= 11'sd0;
            NB_TARGET_MV <= 12'h000;
            CORE_TARGET_MV <= 12'h000;
            NB_OVP_MV <= `RCFG_OVP_FLOOR_MV;
            CORE_OVP_MV <= `RCFG_OVP_FLOOR_MV;
            CORE_PG_HI_MV <= 12'h000;
            CORE_PG_LO_MV <= 12'h000;
            NB_PG_LO_MV <= 12'h000;
            CORE_PG_HI_REL_MV <= 12'h000;
            CORE_PG_LO_REL_MV <= 12'h000;
            NB_PG_LO_REL_MV <= 12'h000;
            PS_PHASES <= 2'h2;
            PS_ADD_CYC <= 3'h1;
            PS_DROP_CYC <= 3'h1;
            CORE_OFS_OFF <= 1'b0;
        end else begin
            SDA_DRV <= 1'b0;
            NB_OFFSET_MV <= nbo_d;
            CORE_OFFSET_MV <= coo_d;
            NB_TARGET_MV <= nbt_d;
            CORE_TARGET_MV <= cot_d;
            NB_OVP_MV <= nbv_d;
            CORE_OVP_MV <= cov_d;
            CORE_PG_HI_MV <= chi_d;
            CORE_PG_LO_MV <= clo_d;
            NB_PG_LO_MV <= nlo_d;
            CORE_PG_HI_REL_MV <= sat12(chi_d, -`RCFG_PG_HYST_MV);
            CORE_PG_LO_REL_MV <= sat12(clo_d, `RCFG_PG_HYST_MV);
            NB_PG_LO_REL_MV <= sat12(nlo_d, `RCFG_PG_HYST_MV);
            PS_PHASES <= app_q[2][`RCFG_PS_PH_LSB + 1] ? 2'h3 : (app_q[2][0] ? 2'h2 : 2'h1);
            PS_ADD_CYC <= cyc_of(app_q[2][`RCFG_PS_ADD_LSB +: 2]);
            PS_DROP_CYC <= cyc_of(app_q[2][`RCFG_PS_DROP_LSB +: 2]);
            CORE_OFS_OFF <= ofs_off_d;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESETN);

    init_hold_a: assert property (!seen_q |-> PS_CTRL == `RCFG_PS_INIT && NB_MARGIN == 8'h00)
        else $error("registers not at initial state after reset");
    por_force_a: assert property (!por_ok |=> shd_q[2] == `RCFG_PS_INIT && PS_CTRL == `RCFG_PS_INIT
        && CORE_MARGIN == `RCFG_CORE_INIT)
        else $error("supply drop did not restore initial states");
    addr_ack_a: assert property (quiet && scl_fall && st_q == ST_ADDR && cnt_q == 4'h8
        && sh_q[7:1] == SLAVE_ADDR |=> SDA_OE && st_q == ST_ACK)
        else $error("own address not acknowledged");
    wr_store_a: assert property (quiet && scl_fall && st_q == ST_WDATA && cnt_q == 4'h8
        && ptr_q < `RCFG_NUM_REGS |=> shd_q[$past(ptr_q[1:0])] == $past(sh_q)
        && ptr_q == $past(ptr_q) + 8'h01 && SDA_OE)
        else $error("data byte not stored or pointer not advanced");
    apply_stop_a: assert property (stop_det && por_ok |=> NB_MARGIN == $past(shd_q[0])
        && CORE_MARGIN == $past(shd_q[1]) && PS_CTRL == $past(shd_q[2]))
        else $error("stop did not apply register contents");
    apply_hold_a: assert property (!stop_det && por_ok |=> $stable(PS_CTRL)
        && $stable(NB_MARGIN))
        else $error("applied contents changed without stop");
    rd_nack_a: assert property (quiet && st_q == ST_RACK && scl_fall && !mack_q
        |=> st_q == ST_IDLE && !SDA_OE)
        else $error("read not ended on master nack");
    rd_next_a: assert property (quiet && st_q == ST_RACK && scl_fall && mack_q
        |=> st_q == ST_RDATA && tx_q == rd_byte($past(ptr_q) + 8'h01))
        else $error("next register not loaded on master ack");
    ovp_level_a: assert property (seen_q && NB_DAC_MV == 12'd1500 && $stable(NB_DAC_MV)
        |=> NB_OVP_MV == ($past(NB_MARGIN[7]) ? 12'd2000 : 12'd1800))
        else $error("north bridge ovp level wrong");
    pg_hyst_a: assert property (seen_q |-> CORE_PG_LO_REL_MV == CORE_PG_LO_MV + 12'd50
        && NB_PG_LO_REL_MV == NB_PG_LO_MV + 12'd50)
        else $error("pgood hysteresis not 50 mV");
    ofs_step_a: assert property (1'b1 |=> NB_OFFSET_MV == $past($signed(NB_MARGIN[5:0])) * 11'sd25)
        else $error("offset step wrong");

    seq_wr_c: cover property (st_q == ST_ACK && ptr_q == 8'h03 && aft_q == ST_WDATA);
    seq_rd_c: cover property (st_q == ST_RACK && ptr_q == 8'h02 && scl_fall && mack_q);
    por_drop_c: cover property (por_ok ##1 !por_ok);

endmodule : rcfg_regs_top

/* rcfg_master_model.sv */
// two-wire bus master model at the far side of the config bank
// assumes the bench resolves the open-drain data wire with a pull-up
`timescale 1ns/1ps
`include "rcfg_map.svh"
module rcfg_master_model (
    input wire logic clk,
    input wire logic sda_in,
    output logic scl,
    output logic sda_low
);
    // ----
    // bus cycles
    // ----
    int hp = 6;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic half;
        repeat (hp) @(negedge clk);
    endtask : half
    task automatic start_cond;
        sda_low = 1'b1;
        half();
        scl = 1'b0;
    endtask : start_cond
    task automatic stop_cond;
        repeat (2) @(negedge clk);
        sda_low = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b0;
        half();
    endtask : stop_cond
    // data moves only while the clock line is low
    task automatic clock_bit(input logic pull, output logic seen);
        repeat (2) @(negedge clk);
        sda_low = pull;
        half();
        scl = 1'b1;
        half();
        seen = sda_in;
        scl = 1'b0;
    endtask : clock_bit
    task automatic xfer_byte(input logic [7:0] tx, input logic mack,
                             output logic [7:0] rx, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(!tx[i], s);
            rx[i] = s;
        end
        clock_bit(mack, s);
        ack = !s;
    endtask : xfer_byte
    // ----
    // transactions
    // ----
    task automatic write_regs(input logic [7:0] ctrl, input logic [7:0] ptr,
                              input logic [23:0] data, input int n, output int acks);
        logic [7:0] rx;
        logic a;
        acks = 0;
        start_cond();
        xfer_byte(ctrl, 1'b0, rx, a);
        acks += int'(a);
        xfer_byte(ptr, 1'b0, rx, a);
        acks += int'(a);
        for (int i = 0; i < n; i++) begin
            xfer_byte(data[8*i +: 8], 1'b0, rx, a);
            acks += int'(a);
        end
        stop_cond();
    endtask : write_regs
    // pointer set and stop, then a read acking all but the last byte
    task automatic read_regs(input logic [7:0] ptr, input int n,
                             output logic [23:0] data, output int acks);
        logic [7:0] rx;
        logic a;
        write_regs({`RCFG_SLAVE_ADDR, 1'b0}, ptr, 24'h000000, 0, acks);
        start_cond();
        xfer_byte({`RCFG_SLAVE_ADDR, 1'b1}, 1'b0, rx, a);
        acks += int'(a);
        data = 24'h000000;
        for (int i = 0; i < n; i++) begin
            xfer_byte(8'hff, i < n - 1, rx, a);
            data[8*i +: 8] = rx;
        end
        stop_cond();
    endtask : read_regs
endmodule : rcfg_master_model

/* test_regulator_i2c_config_regs.sv */
// self-checking bench for the config bank behind its two-wire slave port
// assumes rcfg_master_model as bus master and a pull-up on the data wire
`timescale 1ns/1ps
`include "rcfg_map.svh"
module test_regulator_i2c_config_regs;
    typedef struct packed {
        logic [7:0] ptr;
        logic [1:0] n;
        logic [23:0] data;
        logic [11:0] nb_dac;
        logic [11:0] core_dac;
        logic save;
    } rcfg_row_s;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic por_ok = 1'b1;
    logic save = 1'b0;
    logic [11:0] nb_dac = 12'd1000;
    logic [11:0] core_dac = 12'd1000;
    logic scl, sda_low, sda_oe, sda_drv, ofs_off;
    logic [7:0] nb_m, core_m, ps_c;
    logic [11:0] nb_tgt, core_tgt, nb_ovp, core_ovp, c_hi, c_lo, n_lo, c_hir, c_lor, n_lor;
    logic signed [10:0] nb_ofs, core_ofs;
    logic [1:0] phases;
    logic [2:0] add_cyc, drop_cyc;
    logic [7:0] shadow [3];
    logic [23:0] rd;
    int miscompares = 0;
    int tests_run = 0;
    int acks;
    wire logic sda_w = !(sda_low || (sda_oe && !sda_drv));
    rcfg_row_s rows [8] = '{
        '{8'h00, 2'd3, 24'h5b609f, 12'd1500, 12'd1500, 1'b1},
        '{8'h01, 2'd1, 24'h0000a1, 12'd100, 12'd3000, 1'b0},
        '{8'h02, 2'd2, 24'h00ff36, 12'd1800, 12'd900, 1'b1},
        '{8'h00, 2'd2, 24'h001f60, 12'd200, 12'd4000, 1'b1},
        '{8'h03, 2'd1, 24'h0000ff, 12'd200, 12'd4000, 1'b0},
        '{8'h02, 2'd1, 24'h000028, 12'd700, 12'd1100, 1'b1},
        '{8'h00, 2'd3, 24'h010000, 12'd1000, 12'd1300, 1'b0},
        '{8'h00, 2'd3, 24'h00c53c, 12'd1300, 12'd1250, 1'b1}
    };
    rcfg_master_model m (.clk(mclk), .sda_in(sda_w), .scl(scl), .sda_low(sda_low));
    rcfg_regs_top uut (
        .MCLK(mclk), .RESETN(resetn), .SCL(scl), .SDA(sda_w), .SDA_DRV(sda_drv),
        .SDA_OE(sda_oe), .POR_OK(por_ok), .NB_DAC_MV(nb_dac), .CORE_DAC_MV(core_dac),
        .SAVE_MODE(save), .NB_MARGIN(nb_m), .CORE_MARGIN(core_m), .PS_CTRL(ps_c),
        .NB_TARGET_MV(nb_tgt), .CORE_TARGET_MV(core_tgt), .NB_OFFSET_MV(nb_ofs),
        .CORE_OFFSET_MV(core_ofs), .NB_OVP_MV(nb_ovp), .CORE_OVP_MV(core_ovp),
        .CORE_PG_HI_MV(c_hi), .CORE_PG_LO_MV(c_lo), .NB_PG_LO_MV(n_lo),
        .CORE_PG_HI_REL_MV(c_hir), .CORE_PG_LO_REL_MV(c_lor), .NB_PG_LO_REL_MV(n_lor),
        .PS_PHASES(phases), .PS_ADD_CYC(add_cyc), .PS_DROP_CYC(drop_cyc),
        .CORE_OFS_OFF(ofs_off)
    );
    always #12.5 mclk = ~mclk;
    // ----
    // checking
    // ----
    task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : close_out
    function automatic logic [11:0] clamp(input int v);
        return (v < 0) ? 12'h000 : (v > 4095) ? 12'hfff : 12'(v);
    endfunction : clamp
    function automatic logic [23:0] cyc(input logic [1:0] c);
        return (c == 2'd3) ? 24'd0 : 24'd1 << c;
    endfunction : cyc
    task automatic load_init;
        shadow = '{`RCFG_NB_INIT, `RCFG_CORE_INIT, `RCFG_PS_INIT};
    endtask : load_init
    task automatic check_side(input string nm, input logic [7:0] mr, input int dac,
            input logic off, input logic [11:0] tgt, input logic signed [10:0] ofs,
            input logic [11:0] over_voltage_trip, input logic [11:0] lo, input logic [11:0] lor);
        int o, v;
        logic signed [10:0] eo;
        o = $signed(mr[5:0]) * 25;
        eo = 11'(o);
        chk({nm, "_offset"}, 24'(eo), 24'(ofs));
        chk({nm, "_target"}, 24'(off ? clamp(dac) : clamp(dac + o)), 24'(tgt));
        v = dac + (mr[7] ? 500 : 250);
        chk({nm, "_ovp"}, 24'(clamp(v > 1800 ? v : 1800)), 24'(over_voltage_trip));
        v = int'(clamp(dac - (mr[6] ? 350 : 300)));
        chk({nm, "_pg_lo"}, 24'(v), 24'(lo));
        chk({nm, "_pg_lo_rel"}, 24'(clamp(v + 50)), 24'(lor));
    endtask : check_side
    task automatic check_all;
        int v;
        chk("nb_margin", 24'(shadow[0]), 24'(nb_m));
        chk("core_margin", 24'(shadow[1]), 24'(core_m));
        chk("ps_ctrl", 24'(shadow[2]), 24'(ps_c));
        check_side("nb", shadow[0], int'(nb_dac), 1'b0, nb_tgt, nb_ofs, nb_ovp, n_lo, n_lor);
        check_side("core", shadow[1], int'(core_dac), save & shadow[2][6], core_tgt,
                   core_ofs, core_ovp, c_lo, c_lor);
        v = int'(clamp(int'(core_dac) + (shadow[1][6] ? 300 : 250)));
        chk("core_pg_hi", 24'(v), 24'(c_hi));
        chk("core_pg_hi_rel", 24'(clamp(v - 50)), 24'(c_hir));
        chk("ps_phases", shadow[2][1] ? 24'd3 : 24'(shadow[2][0]) + 24'd1, 24'(phases));
        chk("ps_add", cyc(shadow[2][3:2]), 24'(add_cyc));
        chk("ps_drop", cyc(shadow[2][5:4]), 24'(drop_cyc));
        chk("ofs_off", 24'(save & shadow[2][6]), 24'(ofs_off));
    endtask : check_all
    task automatic do_row(input rcfg_row_s r);
        int ea;
        nb_dac = r.nb_dac;
        core_dac = r.core_dac;
        save = r.save;
        m.write_regs({`RCFG_SLAVE_ADDR, 1'b0}, r.ptr, r.data, int'(r.n), acks);
        ea = (r.ptr < 8'h03) ? 2 : 1;
        for (int i = 0; i < int'(r.n); i++)
            if (int'(r.ptr) + i < 3) begin
                shadow[int'(r.ptr) + i] = r.data[8*i +: 8];
                ea++;
            end
        chk("acks", 24'(ea), 24'(acks));
        repeat (4) @(negedge mclk);
        check_all();
    endtask : do_row
    // ----
    // sequence
    // ----
    initial begin
        load_init();
        repeat (20) @(negedge mclk);
        chk("reset_ps", 24'(`RCFG_PS_INIT), 24'(ps_c));
        chk("reset_oe", 24'd0, 24'(sda_oe));
        resetn = 1'b1;
        repeat (4) @(negedge mclk);
        check_all();
        $display("test reset_values done");
        foreach (rows[i])
            do_row(rows[i]);
        $display("test row_table done");
        m.read_regs(8'h00, 3, rd, acks);
        chk("read_all", {shadow[2], shadow[1], shadow[0]}, rd);
        chk("read_all_acks", 24'd3, 24'(acks));
        m.read_regs(8'h01, 1, rd, acks);
        chk("read_one", 24'(shadow[1]), rd);
        $display("test reads done");
        m.write_regs(8'h8e, 8'h00, 24'h0000ff, 1, acks);
        chk("foreign_acks", 24'd0, 24'(acks));
        repeat (4) @(negedge mclk);
        check_all();
        $display("test foreign_address done");
        por_ok = 1'b0;
        repeat (6) @(negedge mclk);
        por_ok = 1'b1;
        load_init();
        repeat (4) @(negedge mclk);
        check_all();
        do_row(rows[0]);
        $display("test supply_drop done");
        m.hp = 20;
        do_row(rows[3]);
        m.hp = 6;
        resetn = 1'b0;
        repeat (3) @(negedge mclk);
        chk("rerun_nb", 24'(`RCFG_NB_INIT), 24'(nb_m));
        resetn = 1'b1;
        load_init();
        repeat (4) @(negedge mclk);
        check_all();
        $display("test slow_master_and_reset done");
        close_out();
    end
    initial begin
        #2ms;
        miscompares++;
        $display("Error watchdog expected finish seen hang");
        close_out();
    end
endmodule : test_regulator_i2c_config_regs
